/* File: logic/bsc_defines.vh */
/*
  Constants for the BEMF sampling control block: register offsets, field
  positions, reset values and timing figures.
  Assumes a 100 MHz ref_clk and an Avalon-MM slave with byte addresses.
*/
`ifndef BSC_DEFINES_VH
`define BSC_DEFINES_VH

// Register byte offsets
`define BSC_ADDR_CTRL 4'h0
`define BSC_ADDR_FILT 4'h4
`define BSC_ADDR_TIME 4'h8
`define BSC_ADDR_STAT 4'hc

// Control register fields
`define BSC_CTRL_SENSOR 0
`define BSC_CTRL_HFZ 1
`define BSC_CTRL_MOE 2
`define BSC_CTRL_ZKEEP 3
`define BSC_CTRL_OFFSEL 4
`define BSC_CTRL_VMODE 5
`define BSC_CTRL_SOIE 6
`define BSC_CTRL_PIN_LO 8
`define BSC_CTRL_PIN_HI 9
`define BSC_CTRL_DEXP 10
`define BSC_CTRL_ZEXP 11
`define BSC_CTRL_GRP_LO 12
`define BSC_CTRL_GRP_HI 14
`define BSC_CTRL_RST 15'h0000

// Filter register fields
`define BSC_FILT_CWIN_LO 0
`define BSC_FILT_CWIN_HI 3
`define BSC_FILT_DEV_LO 4
`define BSC_FILT_DEV_HI 7
`define BSC_FILT_ZWIN_LO 8
`define BSC_FILT_ZWIN_HI 11
`define BSC_FILT_ZEV_LO 12
`define BSC_FILT_ZEV_HI 15
`define BSC_FILT_RST 16'h0000

// Timing register fields
`define BSC_TIME_DS_LO 0
`define BSC_TIME_DS_HI 3
`define BSC_TIME_OT_LO 4
`define BSC_TIME_OT_HI 7
`define BSC_TIME_RST 8'h00

// Status register fields
`define BSC_STAT_SOF 0
`define BSC_STAT_LVL 1
`define BSC_STAT_PWM 2
`define BSC_STAT_PH_LO 4
`define BSC_STAT_PH_HI 5
`define BSC_STAT_FULL 6

// Timing: figures in ns, rate in MHz
`define BSC_CLK_MHZ 100
`define BSC_DELAY_STEP_NS 2500
`define BSC_NOISE_NS 1000
`define BSC_MIN_OFF_STEP_NS 1000
`define BSC_DELAY_STEP_CYC ((`BSC_DELAY_STEP_NS * `BSC_CLK_MHZ) / 1000)
`define BSC_NOISE_CYC ((`BSC_NOISE_NS * `BSC_CLK_MHZ) / 1000)
`define BSC_MIN_OFF_STEP_CYC ((`BSC_MIN_OFF_STEP_NS * `BSC_CLK_MHZ) / 1000)

`endif

/* File: logic/bsc_sampling_ctrl.v */
/*
  BEMF / hall sampling control: sampling PWM shaping, D and Z sample strobes,
  delayed ON-time sampling, commutation noise blanking, window and event
  filters, sample-out flag, and an Avalon-MM register slave.
  Assumes all inputs are synchronous to ref_clk and that highSampleTick is a
  one-cycle enable at the selected high sampling rate made outside.
*/
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "bsc_defines.vh"

// Summary of operation
// - Sensor mode forces minimum off time zero and permits 100% duty.
// - Sensor mode: Z count filter sets consecutive matching Z samples needed.
// - Sensorless default: one Z sample per PWM period, end of off time.
// - Current mode PWM from measure window, current comparator and min off period.
// - Voltage mode PWM from compare input; current limit forces off, extending off.
// - D sampling always at high sampling rate, independent of PWM and Z type.
// - Sensor mode: no D; Z samples hall input at high rate, any window.
// - High-freq Z bit: Z sampled at high rate on and off; min off zero.
// - Delay field adds value times 2.5us before ON-time Z sample; zero none.
// - Nonzero delay forces min off zero and permits full duty.
// - Delayed sample outside ON time discarded, flag set; irq only with delay.
// - High-freq plus delay: high-rate window after delay until PWM off.
// - Outputs off, sensorless, PWM-rate: keep-running bit decides Z sampling; D continues.
// - End-of-off Z sampling: unselected inputs grounded or floating per select bit.
// - Z consecutive-sample counter works in every configuration.
// - One microsecond noise filter blanks samples after each PWM transition.
// - Noise filter always on D; on Z only with high-freq and zero delay.
// - Sensor mode: group select bit one disabled, no Z window filter.
// - Sensorless filter order C window, D event, Z window, Z event.
// - Delay without high-freq: one Z sample per period, only in ON time.
// - Sensor select bit set chooses hall sensor mode, clear sensorless.
module bsc_sampling_ctrl (
  input wire ref_clk,
  input wire reset,
  input wire [3:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWriteData,
  output reg [31:0] avsReadData,
  output wire avsWaitRequest,
  input wire rotorInputA,
  input wire rotorInputB,
  input wire rotorInputC,
  input wire phaseCompOut,
  input wire currentCompOut,
  input wire measureWindowOut,
  input wire pwmCompareOut,
  input wire currentLimitHit,
  input wire highSampleTick,
  input wire commutationPulse,
  output reg samplingPwmOn,
  output reg dSampleStrobe,
  output reg zSampleStrobe,
  output reg dEvent,
  output reg zEvent,
  output reg [1:0] stepPhase,
  output reg fullDutyAllowed,
  output reg [2:0] groupSelectOut,
  output reg [2:0] pinGroundEn,
  output reg sampleOutIrq
);

  localparam PH_BEFORE_D = 2'd0;
  localparam PH_BETWEEN = 2'd1;
  localparam PH_AFTER_Z = 2'd2;
  localparam [11:0] DELAY_STEP_CYC = `BSC_DELAY_STEP_CYC;
  localparam [11:0] NOISE_CYC = `BSC_NOISE_CYC;
  localparam [11:0] MIN_OFF_STEP_CYC = `BSC_MIN_OFF_STEP_CYC;

  reg ack_ff;
  reg [14:0] ctrl_ff;
  reg [15:0] filt_ff;
  reg [7:0] time_ff;
  reg sampleOut_ff;
  reg pwmOn_ff;
  reg [11:0] offCnt_ff;
  reg limitHold_ff;
  reg [11:0] blankCnt_ff;
  reg [11:0] dlyCnt_ff;
  reg dlyRun_ff;
  reg hfWin_ff;
  reg [1:0] phase_ff;
  reg [3:0] winCnt_ff;
  reg [3:0] evCnt_ff;

  reg nxt_pwmOn;
  reg [31:0] nxt_readData;
  reg selLevel;
  reg zSample;
  reg dSample;

  wire sensorMode = ctrl_ff[`BSC_CTRL_SENSOR];
  wire hfZ = ctrl_ff[`BSC_CTRL_HFZ];
  wire voltMode = ctrl_ff[`BSC_CTRL_VMODE];
  wire [1:0] pinSel = ctrl_ff[`BSC_CTRL_PIN_HI:`BSC_CTRL_PIN_LO];
  wire [3:0] delaySel = time_ff[`BSC_TIME_DS_HI:`BSC_TIME_DS_LO];
  wire [3:0] minOffSel = time_ff[`BSC_TIME_OT_HI:`BSC_TIME_OT_LO];
  wire delayOn = (delaySel != 4'h0);
  wire zeroMinOff = sensorMode | hfZ | delayOn;
  wire [11:0] minOffCyc = zeroMinOff ? 12'h000 : {8'h00, minOffSel} * MIN_OFF_STEP_CYC;
  wire [11:0] delayCyc = {8'h00, delaySel} * DELAY_STEP_CYC;
  wire blanked = (blankCnt_ff != 12'h000);
  wire pwmRise = ~pwmOn_ff & nxt_pwmOn;
  wire dlyExpire = dlyRun_ff & (dlyCnt_ff == 12'h001);
  wire typeEndOff = ~sensorMode & ~hfZ & ~delayOn;
  wire busReq = avsRead | avsWrite;
  wire busTake = busReq & ack_ff;
  wire zAllowed = (phase_ff == PH_BETWEEN) & (sensorMode | ctrl_ff[`BSC_CTRL_MOE] | hfZ |
                  ctrl_ff[`BSC_CTRL_ZKEEP]);
  wire expectLvl = (phase_ff == PH_BEFORE_D) ? ctrl_ff[`BSC_CTRL_DEXP] : ctrl_ff[`BSC_CTRL_ZEXP];
  wire [3:0] evNeed = (phase_ff == PH_BEFORE_D) ? filt_ff[`BSC_FILT_DEV_HI:`BSC_FILT_DEV_LO] :
                      filt_ff[`BSC_FILT_ZEV_HI:`BSC_FILT_ZEV_LO];

  // One wait state per access; the answer comes on the second edge
  assign avsWaitRequest = busReq & ~ack_ff;

  // Selected input: hall pin in sensor mode, phase comparator otherwise, zero for pin select 3
  always @* begin
    case (pinSel)
      2'd0: selLevel = sensorMode ? rotorInputA : phaseCompOut;
      2'd1: selLevel = sensorMode ? rotorInputB : phaseCompOut;
      2'd2: selLevel = sensorMode ? rotorInputC : phaseCompOut;
      default: selLevel = 1'b0;
    endcase
  end

  // Sampling PWM next state for current and voltage mode
  always @* begin
    nxt_pwmOn = pwmOn_ff;
    if (pwmOn_ff) begin
      if (voltMode ? (~pwmCompareOut | currentLimitHit) : currentCompOut) begin
        nxt_pwmOn = 1'b0;
      end
    end else if (offCnt_ff == 12'h000) begin
      if (voltMode ? (pwmCompareOut & ~limitHold_ff) : measureWindowOut) begin
        nxt_pwmOn = 1'b1;
      end
    end
  end

  // Sample strobes for D and Z
  always @* begin
    dSample = (phase_ff == PH_BEFORE_D) & ~sensorMode & highSampleTick & ~blanked;
    if (!zAllowed) begin
      zSample = 1'b0;
    end else if (sensorMode) begin
      zSample = highSampleTick;
    end else if (!hfZ && !delayOn) begin
      zSample = pwmRise;
    end else if (hfZ && !delayOn) begin
      zSample = highSampleTick & ~blanked;
    end else if (!hfZ) begin
      zSample = dlyExpire & pwmOn_ff;
    end else begin
      zSample = highSampleTick & hfWin_ff & pwmOn_ff;
    end
  end

  // Register read mux
  always @* begin
    nxt_readData = 32'h00000000;
    case (avsAddress)
      `BSC_ADDR_CTRL: nxt_readData[14:0] = ctrl_ff;
      `BSC_ADDR_FILT: nxt_readData[15:0] = filt_ff;
      `BSC_ADDR_TIME: nxt_readData[7:0] = time_ff;
      `BSC_ADDR_STAT: begin
        nxt_readData[`BSC_STAT_SOF] = sampleOut_ff;
        nxt_readData[`BSC_STAT_LVL] = selLevel;
        nxt_readData[`BSC_STAT_PWM] = pwmOn_ff;
        nxt_readData[`BSC_STAT_PH_HI:`BSC_STAT_PH_LO] = phase_ff;
        nxt_readData[`BSC_STAT_FULL] = zeroMinOff;
      end
      default: nxt_readData = 32'h00000000;
    endcase
  end

  // Bus slave and configuration registers
  always @(posedge ref_clk) begin
    if (reset) begin
      ack_ff <= 1'b0;
      avsReadData <= 32'h00000000;
      ctrl_ff <= `BSC_CTRL_RST;
      filt_ff <= `BSC_FILT_RST;
      time_ff <= `BSC_TIME_RST;
    end else begin
      ack_ff <= busReq & ~ack_ff;
      if (avsRead && !ack_ff) begin
        avsReadData <= nxt_readData;
      end
      if (avsWrite && busTake) begin
        case (avsAddress)
          `BSC_ADDR_CTRL: ctrl_ff <= avsWriteData[14:0];
          `BSC_ADDR_FILT: filt_ff <= avsWriteData[15:0];
          `BSC_ADDR_TIME: time_ff <= avsWriteData[7:0];
          default: ctrl_ff <= ctrl_ff;
        endcase
      end
    end
  end

  // Sample-out flag; a new event wins over a software clear
  always @(posedge ref_clk) begin
    if (reset) begin
      sampleOut_ff <= 1'b0;
    end else if (dlyExpire && !pwmOn_ff && zAllowed) begin
      sampleOut_ff <= 1'b1;
    end else if (avsWrite && busTake && avsAddress == `BSC_ADDR_STAT && avsWriteData[`BSC_STAT_SOF]) begin
      sampleOut_ff <= 1'b0;
    end
  end

  // PWM state, min off counter and current-limit hold to the next period
  always @(posedge ref_clk) begin
    if (reset) begin
      pwmOn_ff <= 1'b0;
      offCnt_ff <= 12'h000;
      limitHold_ff <= 1'b0;
    end else begin
      pwmOn_ff <= nxt_pwmOn;
      if (pwmOn_ff && !nxt_pwmOn) begin
        offCnt_ff <= minOffCyc;
      end else if (offCnt_ff != 12'h000) begin
        offCnt_ff <= offCnt_ff - 12'h001;
      end
      if (voltMode && currentLimitHit) begin
        limitHold_ff <= 1'b1;
      end else if (!pwmCompareOut) begin
        limitHold_ff <= 1'b0;
      end
    end
  end

  // Noise blanking after each PWM edge, then the ON-time delay and window
  always @(posedge ref_clk) begin
    if (reset) begin
      blankCnt_ff <= 12'h000;
      dlyCnt_ff <= 12'h000;
      dlyRun_ff <= 1'b0;
      hfWin_ff <= 1'b0;
    end else begin
      if (pwmOn_ff != nxt_pwmOn) begin
        blankCnt_ff <= NOISE_CYC;
      end else if (blanked) begin
        blankCnt_ff <= blankCnt_ff - 12'h001;
      end
      if (pwmRise && delayOn && !sensorMode) begin
        dlyRun_ff <= 1'b1;
        dlyCnt_ff <= delayCyc;
      end else if (dlyExpire) begin
        dlyRun_ff <= 1'b0;
        dlyCnt_ff <= 12'h000;
      end else if (dlyRun_ff) begin
        dlyCnt_ff <= dlyCnt_ff - 12'h001;
      end
      if (!pwmOn_ff || !hfZ || !delayOn) begin
        hfWin_ff <= 1'b0;
      end else if (dlyExpire) begin
        hfWin_ff <= 1'b1;
      end
    end
  end

  // Step phase with window and consecutive-event filters
  always @(posedge ref_clk) begin
    if (reset) begin
      phase_ff <= PH_BEFORE_D;
      winCnt_ff <= 4'h0;
      evCnt_ff <= 4'h0;
    end else if (commutationPulse) begin
      phase_ff <= sensorMode ? PH_BETWEEN : PH_BEFORE_D;
      winCnt_ff <= sensorMode ? 4'h0 : filt_ff[`BSC_FILT_CWIN_HI:`BSC_FILT_CWIN_LO];
      evCnt_ff <= 4'h0;
    end else if (dSample || zSample) begin
      case (phase_ff)
        PH_BEFORE_D, PH_BETWEEN: begin
          if (winCnt_ff != 4'h0) begin
            winCnt_ff <= winCnt_ff - 4'h1;
          end else if (selLevel != expectLvl) begin
            evCnt_ff <= 4'h0;
          end else if (evCnt_ff >= evNeed) begin
            evCnt_ff <= 4'h0;
            phase_ff <= (phase_ff == PH_BEFORE_D) ? PH_BETWEEN : PH_AFTER_Z;
            winCnt_ff <= (phase_ff == PH_BEFORE_D) ? filt_ff[`BSC_FILT_ZWIN_HI:`BSC_FILT_ZWIN_LO] : 4'h0;
          end else begin
            evCnt_ff <= evCnt_ff + 4'h1;
          end
        end
        default: phase_ff <= phase_ff;
      endcase
    end
  end

  // Registered outputs
  always @(posedge ref_clk) begin
    if (reset) begin
      samplingPwmOn <= 1'b0;
      dSampleStrobe <= 1'b0;
      zSampleStrobe <= 1'b0;
      dEvent <= 1'b0;
      zEvent <= 1'b0;
      stepPhase <= PH_BEFORE_D;
      fullDutyAllowed <= 1'b0;
      groupSelectOut <= 3'h0;
      pinGroundEn <= 3'h0;
      sampleOutIrq <= 1'b0;
    end else begin
      samplingPwmOn <= pwmOn_ff;
      dSampleStrobe <= dSample;
      zSampleStrobe <= zSample;
      dEvent <= ~commutationPulse & dSample & (phase_ff == PH_BEFORE_D) & (winCnt_ff == 4'h0) &
                (selLevel == expectLvl) & (evCnt_ff >= evNeed);
      zEvent <= ~commutationPulse & zSample & (phase_ff == PH_BETWEEN) & (winCnt_ff == 4'h0) &
                (selLevel == expectLvl) & (evCnt_ff >= evNeed);
      stepPhase <= phase_ff;
      fullDutyAllowed <= zeroMinOff;
      groupSelectOut <= ctrl_ff[`BSC_CTRL_GRP_HI:`BSC_CTRL_GRP_LO] & (sensorMode ? 3'b101 : 3'b111);
      // Unselected sensorless inputs grounded only for end-of-off sampling
      pinGroundEn <= (typeEndOff & ctrl_ff[`BSC_CTRL_OFFSEL]) ? ~(3'b001 << pinSel) : 3'h0;
      sampleOutIrq <= sampleOut_ff & ctrl_ff[`BSC_CTRL_SOIE] & delayOn;
    end
  end

endmodule

/* File: tb/bsc_sampling_chk.sv */
/*
  Checker for the sampling control block: bus wait, strobes, events, step phase.
  Assumes it is bound to bsc_sampling_ctrl and sees only that module's ports.
*/
`timescale 1ns/1ps
module bsc_sampling_chk (
  input wire ref_clk,
  input wire reset,
  input wire avsRead,
  input wire avsWrite,
  input wire avsWaitRequest,
  input wire highSampleTick,
  input wire commutationPulse,
  input wire samplingPwmOn,
  input wire dSampleStrobe,
  input wire zSampleStrobe,
  input wire dEvent,
  input wire zEvent,
  input wire [1:0] stepPhase
);
  reg prevPwm_ff;
  reg [7:0] sinceEdge_ff;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Cycles since the sampling PWM last changed, saturating
  always @(posedge ref_clk) begin
    prevPwm_ff <= samplingPwmOn;
    if (reset) begin
      sinceEdge_ff <= 8'hff;
    end else if (samplingPwmOn != prevPwm_ff) begin
      sinceEdge_ff <= 8'h00;
    end else if (sinceEdge_ff != 8'hff) begin
      sinceEdge_ff <= sinceEdge_ff + 8'h01;
    end
  end
  a_wait_idle: assert property (!(avsRead || avsWrite) |-> !avsWaitRequest)
    else $error("waitrequest high with no request");
  a_wait_once: assert property ($rose(avsRead || avsWrite) |-> avsWaitRequest ##1 !avsWaitRequest)
    else $error("waitrequest did not drop after one cycle");
  a_dstrobe_tick: assert property (dSampleStrobe |-> $past(highSampleTick))
    else $error("D strobe without high rate tick");
  a_devent_strobe: assert property (dEvent |-> dSampleStrobe)
    else $error("D event without D sample");
  a_zevent_strobe: assert property (zEvent |-> zSampleStrobe)
    else $error("Z event without Z sample");
  a_dphase_set: assert property (dEvent |-> ##[0:1] stepPhase == 2'h1)
    else $error("phase not between D and Z after D event");
  a_zphase_set: assert property (zEvent |-> ##[0:1] stepPhase == 2'h2)
    else $error("phase not after Z after Z event");
  a_comm_restart: assert property (commutationPulse |=> ##1 stepPhase != 2'h2)
    else $error("commutation did not restart the step");
  a_dnoise_blank: assert property (dSampleStrobe |-> sinceEdge_ff >= 8'd95)
    else $error("D sample inside commutation noise blank");
endmodule
bind bsc_sampling_ctrl bsc_sampling_chk chk_u (.*);

/* File: tb/bsc_motor_model.sv */
/*
  Motor side model: hall levels, comparator level, PWM compare, current mode
  window and comparator, high rate sample tick.
  Assumes the bench sets duty, hall and level just after clock edges.
*/
`timescale 1ns/1ps
module bsc_motor_model (
  input wire ref_clk,
  input wire reset,
  input wire [7:0] duty,
  input wire [2:0] hall,
  input wire level,
  output wire highSampleTick,
  output wire pwmCompareOut,
  output wire measureWindowOut,
  output wire currentCompOut,
  output wire rotorInputA,
  output wire rotorInputB,
  output wire rotorInputC,
  output wire phaseCompOut
);
  reg [7:0] pwmCnt_ff;
  reg [3:0] tickCnt_ff;
  // PWM period of 256 cycles, tick every 10 cycles
  always @(posedge ref_clk) begin
    if (reset) begin
      pwmCnt_ff <= 8'h00;
      tickCnt_ff <= 4'h0;
    end else begin
      pwmCnt_ff <= pwmCnt_ff + 8'h01;
      tickCnt_ff <= (tickCnt_ff == 4'h9) ? 4'h0 : tickCnt_ff + 4'h1;
    end
  end
  assign highSampleTick = (tickCnt_ff == 4'h9);
  assign pwmCompareOut = (pwmCnt_ff < duty);
  // Current mode: window at period start, comparator trips at duty
  assign measureWindowOut = (pwmCnt_ff == 8'h00);
  assign currentCompOut = (pwmCnt_ff == duty);
  // Hall levels and comparator level; software selects the pin first
  assign {rotorInputC, rotorInputB, rotorInputA} = hall;
  assign phaseCompOut = level;
endmodule

/* File: tb/tb.sv */
/*
  Testbench: register reads checked through a queue, then mode and step tests.
  Assumes the motor model on the far side and a 100 MHz clock.
*/
`timescale 1ns/1ps
`include "bsc_defines.vh"
module tb;
  reg ref_clk = 1'h0;
  reg reset = 1'h1;
  reg [3:0] avsAddress = 4'h0;
  reg avsRead = 1'h0;
  reg avsWrite = 1'h0;
  reg [31:0] avsWriteData = 32'h0;
  reg currentLimitHit = 1'h0;
  reg commutationPulse = 1'h0;
  reg [7:0] duty = 8'h80;
  reg [2:0] hall = 3'h0;
  reg level = 1'h1;
  reg [31:0] seed = 32'hf0879f90;
  reg [31:0] m;
  reg [31:0] expQ[$];
  reg [31:0] mskQ[$];
  integer numErrors = 0;
  integer checksDone = 0;
  integer i, n, zs, ds;
  wire [31:0] avsReadData;
  wire avsWaitRequest, highSampleTick, pwmCompareOut, measureWindowOut, currentCompOut;
  wire rotorInputA, rotorInputB, rotorInputC, phaseCompOut, samplingPwmOn, dSampleStrobe;
  wire zSampleStrobe, dEvent, zEvent, fullDutyAllowed, sampleOutIrq;
  wire [1:0] stepPhase;
  wire [2:0] groupSelectOut, pinGroundEn;
  bsc_sampling_ctrl dut_u (.*);
  bsc_motor_model model_u (.*);
  always #5 ref_clk = ~ref_clk;
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task check(input [63:0] nm, input [31:0] e, input [31:0] s);
    begin
      checksDone = checksDone + 1;
      if (s !== e) begin
        numErrors = numErrors + 1;
        $display("mismatch %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  // One Avalon access; a read notes its expected value and mask
  task bus(input rd, input [3:0] a, input [31:0] d, input [31:0] k);
    begin
      n = 0;
      avsAddress <= a;
      avsWriteData <= d;
      avsRead <= rd;
      avsWrite <= !rd;
      if (rd) begin
        expQ.push_back(d);
        mskQ.push_back(k);
      end
      @(negedge ref_clk);
      while (avsWaitRequest !== 1'h0 && n < 50) begin
        @(negedge ref_clk);
        n = n + 1;
      end
      if (n >= 50) numErrors = numErrors + 1;
      @(posedge ref_clk);
      avsRead <= 1'h0;
      avsWrite <= 1'h0;
      @(posedge ref_clk);
    end
  endtask
  // Commutation pulse, then count Z strobes and D events until Z
  task step;
    begin
      commutationPulse <= 1'h1;
      @(posedge ref_clk);
      commutationPulse <= 1'h0;
      zs = 0;
      ds = 0;
      n = 0;
      while (zEvent !== 1'h1 && n < 1000) begin
        @(negedge ref_clk);
        zs = zs + zSampleStrobe;
        ds = ds + dEvent;
        n = n + 1;
      end
      // Let the late step phase output settle before anyone looks at it
      @(negedge ref_clk);
      @(posedge ref_clk);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", checksDone, numErrors);
      if (numErrors == 0 && checksDone > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask
  // Compare each completed read with the oldest note
  always @(posedge ref_clk) begin
    if (avsRead && avsWaitRequest === 1'h0) begin
      m = mskQ.pop_front();
      check("readData", expQ.pop_front() & m, avsReadData & m);
    end
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    numErrors = numErrors + 1;
    summarize;
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'h0;
    @(posedge ref_clk);
    for (i = 0; i < 5; i = i + 1) bus(1, (i == 4) ? 4'h1 : {i[1:0], 2'h0}, 0, 32'hfffffff9);
    $display("reset test done");
    for (i = 0; i < 4; i = i + 1) begin
      bus(0, `BSC_ADDR_CTRL, (i == 1) ? 32'h1 : (i == 2) ? 32'h2 : 32'h0, 0);
      bus(0, `BSC_ADDR_TIME, (i == 3) ? 32'h5 : 32'h0, 0);
      bus(1, `BSC_ADDR_STAT, (i != 0) ? 32'h40 : 32'h0, 32'h40);
      check("fullDuty", i != 0, fullDutyAllowed);
    end
    $display("full duty test done");
    for (i = 0; i < 4; i = i + 1) begin
      seed = lfsr(seed);
      hall <= seed[2:0];
      bus(0, `BSC_ADDR_CTRL, 32'h1 | (i << 8), 0);
      bus(1, `BSC_ADDR_STAT, (i < 3) ? {30'h0, seed[i], 1'h0} : 32'h0, 32'h2);
    end
    $display("readback test done");
    duty <= 8'h10;
    // Expected D level matches the comparator so the step reaches the Z phase
    bus(0, `BSC_ADDR_CTRL, 32'h464, 0);
    bus(0, `BSC_ADDR_TIME, 32'h1, 0);
    n = 0;
    while (sampleOutIrq !== 1'h1 && n < 2000) begin
      @(negedge ref_clk);
      n = n + 1;
    end
    check("soIrq", 1, sampleOutIrq);
    @(posedge ref_clk);
    bus(1, `BSC_ADDR_STAT, 32'h1, 32'h1);
    bus(0, `BSC_ADDR_TIME, 32'h0, 0);
    repeat (2) @(negedge ref_clk);
    check("soIrq", 0, sampleOutIrq);
    @(posedge ref_clk);
    $display("sample out test done");
    duty <= 8'h80;
    hall <= 3'h7;
    bus(0, `BSC_ADDR_FILT, 32'h3000, 0);
    bus(0, `BSC_ADDR_CTRL, 32'h805, 0);
    step;
    check("zStrobes", 4, zs);
    check("dEvents", 0, ds);
    check("phase", 2, stepPhase);
    $display("hall step test done");
    bus(0, `BSC_ADDR_FILT, 32'h0, 0);
    for (i = 0; i < 3; i = i + 1) begin
      bus(0, `BSC_ADDR_CTRL, (i == 1) ? 32'hc20 : (i == 2) ? 32'hc28 : 32'hc24, 0);
      step;
      check("zStrobes", i != 1, zs);
      check("dEvents", 1, ds);
    end
    $display("sensorless step test done");
    n = 0;
    while (measureWindowOut !== 1'h1 && n < 300) begin
      @(negedge ref_clk);
      n = n + 1;
    end
    @(posedge ref_clk);
    currentLimitHit <= 1'h1;
    @(posedge ref_clk);
    currentLimitHit <= 1'h0;
    repeat (3) @(negedge ref_clk);
    check("pwmOn", 0, samplingPwmOn);
    $display("current limit test done");
    summarize;
  end
endmodule
